// [src/rsb_cfg.svh]
// Register map, field positions, reset values and timing counts of the reset status block
`ifndef RSB_CFG_SVH
`define RSB_CFG_SVH

`define RSB_ADDR_W              16
`define RSB_DATA_W              8
`define RSB_ADDR_BREAK_STATUS   16'hFE00
`define RSB_ADDR_RESET_STATUS   16'hFE01
`define RSB_ADDR_BREAK_CTRL     16'hFE03
`define RSB_ADDR_IRQ_STATUS     16'hFE04
`define RSB_ADDR_IRQ_MASK       16'hFE05

`define RSB_BIT_BREAK_WAIT      1
`define RSB_BIT_CLEAR_EN        7
`define RSB_BIT_POR             7
`define RSB_BIT_PIN             6
`define RSB_BIT_SRC_HI          5
`define RSB_BIT_SRC_LO          1

`define RSB_IRQ_W               3
`define RSB_IRQ_BREAK_WAIT      0
`define RSB_IRQ_PIN             1
`define RSB_IRQ_SEQ_DONE        2

`define RSB_RST_RESET_STATUS    8'h80
`define RSB_RST_ZERO            8'h00

`define RSB_CLK_PERIOD_NS       40
`define RSB_DRIVE_TIME_NS       1280
`define RSB_DRIVE_CYC           ((`RSB_DRIVE_TIME_NS + `RSB_CLK_PERIOD_NS - 1) / `RSB_CLK_PERIOD_NS)
`define RSB_XTAL_SAMPLE_CYC     32

`endif

// [src/rsb_pkg.sv]
// Types shared by the reset status block
package rsb_pkg;

    typedef enum logic [3:0]
    {
        seq_idle   = 4'h1,
        seq_drive  = 4'h2,
        seq_settle = 4'h4,
        seq_sample = 4'h8
    } rsb_seq_t;

endpackage

// [src/rsb_status.sv]
// Reset source, break status and break clear control registers with reset pin sequencing
`include "rsb_cfg.svh"

// Contract
// - Break status at FE00, reset status at FE01, break control at FE03.
// - Break status register holds a flag for break-caused low-power exit.
// - Break wait flag reads 1 after wait exit by break, else 0.
// - Reset flags accumulate so, once cleared, they show the latest source.
// - Reading reset status clears it until another source sets a flag.
// - Power-on reset sets the power-on flag and clears all others.
// - Power-on or internal reset drives the reset pin low.
// - After pin release wait 32 crystal cycles, sample; low sets pin flag.
// - Pin flag marks external reset; cleared by power-on or read.
// - Watchdog flag set when the watchdog produced the reset.
// - Bad opcode flag set when an illegal opcode caused the reset.
// - Bad address flag set only by illegal fetches, never data accesses.
// - Monitor entry flag set on blank-vector monitor entry with interrupt pin high.
// - Low voltage flag set when the low-voltage circuit caused the reset.
// - Clear enable readable, writable; when 0, break-state accesses clear nothing.
module rsb_status #(
    parameter int DRIVE_CYC = `RSB_DRIVE_CYC,
    parameter int XTAL_CYC  = `RSB_XTAL_SAMPLE_CYC
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    clk_en,
    input  wire logic [`RSB_ADDR_W-1:0]  reg_addr,
    input  wire logic [`RSB_DATA_W-1:0]  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`RSB_DATA_W-1:0]  reg_rdata,
    input  wire logic                    crystal_clock_tick,
    input  wire logic                    rst_pin_n_in,
    output logic                         rst_pin_out,
    output logic                         rst_pin_oe,
    output logic                         core_rst,
    input  wire logic                    break_state,
    input  wire logic                    break_wait_exit,
    input  wire logic                    watchdog_req,
    input  wire logic                    bad_opcode_req,
    input  wire logic                    bad_addr_req,
    input  wire logic                    bad_addr_is_fetch,
    input  wire logic                    monitor_entry_req,
    input  wire logic                    vector_blank,
    input  wire logic                    irq_pin_high,
    input  wire logic                    low_voltage_req,
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    localparam int DW = `RSB_DATA_W;
    localparam int SRC_N = `RSB_BIT_SRC_HI - `RSB_BIT_SRC_LO + 1;

    generate
        if (DRIVE_CYC < 1 || DRIVE_CYC > 255)
        begin : g_bad_drive
            $error("DRIVE_CYC must lie in 1..255");
        end
        if (XTAL_CYC < 1 || XTAL_CYC > 255)
        begin : g_bad_xtal
            $error("XTAL_CYC must lie in 1..255");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    rsb_pkg::rsb_seq_t     seq_ff;
    rsb_pkg::rsb_seq_t     nxt_seq;
    logic [7:0]            drive_cnt_ff;
    logic [7:0]            xtal_cnt_ff;
    logic [DW-1:0]         reset_status_ff;
    logic                  break_wait_ff;
    logic                  clear_en_ff;
    logic [`RSB_IRQ_W-1:0] irq_status_ff;
    logic [`RSB_IRQ_W-1:0] irq_mask_ff;
    logic [DW-1:0]         rdata_ff;
    logic [SRC_N-1:0]      src_vec;
    logic [DW-1:0]         set_vec;
    logic                  clr_ok;
    logic                  any_internal;
    logic                  pin_set;
    logic                  rd_reset_status;
    logic                  rd_irq_status;
    logic                  wr_break_status;
    logic [`RSB_IRQ_W-1:0] irq_set;

    ////////////////////////////////////////////////////////////////////////////////
    // Source decode

    // Data accesses to illegal addresses must not count, so the fetch qualifier gates it
    assign src_vec[4] = watchdog_req;
    assign src_vec[3] = bad_opcode_req;
    assign src_vec[2] = bad_addr_req && bad_addr_is_fetch;
    assign src_vec[1] = monitor_entry_req && vector_blank && irq_pin_high;
    assign src_vec[0] = low_voltage_req;
    assign any_internal = |src_vec;

    // Pin flag: an external low while idle, or still low at the late sample point
    assign pin_set = !rst_pin_n_in
                     && (seq_ff == rsb_pkg::seq_idle || seq_ff == rsb_pkg::seq_sample);

    // Break state protects flags from debugger reads unless clearing is enabled
    assign clr_ok = !break_state || clear_en_ff;

    assign rd_reset_status = reg_rd && reg_addr == `RSB_ADDR_RESET_STATUS;
    assign rd_irq_status   = reg_rd && reg_addr == `RSB_ADDR_IRQ_STATUS;
    assign wr_break_status = reg_wr && reg_addr == `RSB_ADDR_BREAK_STATUS;

    ////////////////////////////////////////////////////////////////////////////////
    // Set vector, one bit per reset source

    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++)
        begin : g_set
            if (gi >= `RSB_BIT_SRC_LO && gi <= `RSB_BIT_SRC_HI)
            begin : g_src
                assign set_vec[gi] = src_vec[gi-`RSB_BIT_SRC_LO];
            end
            else if (gi == `RSB_BIT_PIN)
            begin : g_pin
                assign set_vec[gi] = pin_set;
            end
            else
            begin : g_none
                assign set_vec[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pin sequencer

    always_comb
    begin
        nxt_seq = seq_ff;
        case (seq_ff)
            rsb_pkg::seq_idle:
            begin
                if (any_internal)
                begin
                    nxt_seq = rsb_pkg::seq_drive;
                end
            end
            rsb_pkg::seq_drive:
            begin
                if (drive_cnt_ff == 8'(DRIVE_CYC - 1))
                begin
                    nxt_seq = rsb_pkg::seq_settle;
                end
            end
            rsb_pkg::seq_settle:
            begin
                if (crystal_clock_tick && xtal_cnt_ff == 8'(XTAL_CYC - 1))
                begin
                    nxt_seq = rsb_pkg::seq_sample;
                end
            end
            rsb_pkg::seq_sample:
            begin
                nxt_seq = rsb_pkg::seq_idle;
            end
            default:
            begin
                nxt_seq = rsb_pkg::seq_idle;
            end
        endcase
    end

    // Power-on starts in the drive phase so the pin is pulled low from reset on
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            seq_ff <= rsb_pkg::seq_drive;
        end
        else if (clk_en)
        begin
            seq_ff <= nxt_seq;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            drive_cnt_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            if (seq_ff == rsb_pkg::seq_drive)
            begin
                drive_cnt_ff <= drive_cnt_ff + 8'h01;
            end
            else
            begin
                drive_cnt_ff <= 8'h00;
            end
        end
    end

    // Counts crystal ticks after release; holds its final value through the sample phase
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            xtal_cnt_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            if (seq_ff == rsb_pkg::seq_drive)
            begin
                xtal_cnt_ff <= 8'h00;
            end
            else if (seq_ff == rsb_pkg::seq_settle && crystal_clock_tick)
            begin
                xtal_cnt_ff <= xtal_cnt_ff + 8'h01;
            end
        end
    end

    assign rst_pin_oe  = seq_ff == rsb_pkg::seq_drive;
    assign rst_pin_out = 1'b0;
    assign core_rst    = seq_ff != rsb_pkg::seq_idle || !rst_pin_n_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset source status

    // Flags accumulate; a new source landing on the clearing read survives it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reset_status_ff <= `RSB_RST_RESET_STATUS;
        end
        else if (clk_en)
        begin
            if (rd_reset_status && clr_ok)
            begin
                reset_status_ff <= set_vec;
            end
            else
            begin
                reset_status_ff <= reset_status_ff | set_vec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Break status and break clear control

    // Writing zero to the flag clears it; writing one has no effect
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            break_wait_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (break_wait_exit)
            begin
                break_wait_ff <= 1'b1;
            end
            else if (wr_break_status && clr_ok && !reg_wdata[`RSB_BIT_BREAK_WAIT])
            begin
                break_wait_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clear_en_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == `RSB_ADDR_BREAK_CTRL)
            begin
                clear_en_ff <= reg_wdata[`RSB_BIT_CLEAR_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    assign irq_set[`RSB_IRQ_BREAK_WAIT] = break_wait_exit;
    assign irq_set[`RSB_IRQ_PIN]        = pin_set;
    assign irq_set[`RSB_IRQ_SEQ_DONE]   = seq_ff == rsb_pkg::seq_sample;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_ff <= `RSB_IRQ_W'(0);
        end
        else if (clk_en)
        begin
            if (rd_irq_status && clr_ok)
            begin
                irq_status_ff <= irq_set;
            end
            else
            begin
                irq_status_ff <= irq_status_ff | irq_set;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_ff <= `RSB_IRQ_W'(0);
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == `RSB_ADDR_IRQ_MASK)
            begin
                irq_mask_ff <= reg_wdata[`RSB_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe; unmapped addresses read zero

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= `RSB_RST_ZERO;
        end
        else if (clk_en)
        begin
            if (reg_rd)
            begin
                case (reg_addr)
                    `RSB_ADDR_BREAK_STATUS:
                    begin
                        rdata_ff <= DW'({break_wait_ff, 1'b0});
                    end
                    `RSB_ADDR_RESET_STATUS:
                    begin
                        rdata_ff <= reset_status_ff;
                    end
                    `RSB_ADDR_BREAK_CTRL:
                    begin
                        rdata_ff <= {clear_en_ff, 7'h00};
                    end
                    `RSB_ADDR_IRQ_STATUS:
                    begin
                        rdata_ff <= DW'(irq_status_ff);
                    end
                    `RSB_ADDR_IRQ_MASK:
                    begin
                        rdata_ff <= DW'(irq_mask_ff);
                    end
                    default:
                    begin
                        rdata_ff <= `RSB_RST_ZERO;
                    end
                endcase
            end
            else
            begin
                rdata_ff <= `RSB_RST_ZERO;
            end
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_internal_req;
        clk_en && seq_ff == rsb_pkg::seq_idle && any_internal;
    endsequence

    sequence s_drive_phase;
        seq_ff == rsb_pkg::seq_drive && rst_pin_oe && !rst_pin_out;
    endsequence

    property p_ctrl_readback;
        clk_en && reg_rd && reg_addr == `RSB_ADDR_BREAK_CTRL
        |=> reg_rdata == {$past(clear_en_ff), 7'h00};
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("break control read data wrong");

    property p_read_clears;
        clk_en && rd_reset_status && clr_ok && set_vec == `RSB_RST_ZERO
        |=> reset_status_ff == `RSB_RST_ZERO;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("reset status not cleared by read");

    property p_break_protect;
        rd_reset_status && !clr_ok
        |=> ($past(reset_status_ff) & ~reset_status_ff) == `RSB_RST_ZERO;
    endproperty
    a_break_protect: assert property (p_break_protect)
        else $error("reset status cleared during protected break");

    property p_drive_on_internal;
        s_internal_req |=> s_drive_phase;
    endproperty
    a_drive_on_internal: assert property (p_drive_on_internal)
        else $error("pin not driven low after internal reset");

    property p_sample_after_ticks;
        seq_ff == rsb_pkg::seq_sample |-> xtal_cnt_ff == 8'(XTAL_CYC);
    endproperty
    a_sample_after_ticks: assert property (p_sample_after_ticks)
        else $error("pin sampled at wrong crystal count");

    property p_pin_flag;
        clk_en && seq_ff == rsb_pkg::seq_sample && !rst_pin_n_in
        |=> reset_status_ff[`RSB_BIT_PIN];
    endproperty
    a_pin_flag: assert property (p_pin_flag)
        else $error("pin flag not set at sample");

    property p_wait_flag;
        clk_en && break_wait_exit |=> break_wait_ff;
    endproperty
    a_wait_flag: assert property (p_wait_flag)
        else $error("break wait flag not set");

    property p_fetch_only;
        $rose(reset_status_ff[3]) |-> $past(bad_addr_req && bad_addr_is_fetch);
    endproperty
    a_fetch_only: assert property (p_fetch_only)
        else $error("bad address flag set without a fetch");

    property p_watchdog_flag;
        clk_en && watchdog_req |=> reset_status_ff[5];
    endproperty
    a_watchdog_flag: assert property (p_watchdog_flag)
        else $error("watchdog flag not set");

    property p_low_voltage_flag;
        clk_en && low_voltage_req |=> reset_status_ff[1];
    endproperty
    a_low_voltage_flag: assert property (p_low_voltage_flag)
        else $error("low voltage flag not set");

endmodule

// [testbench/rsb_status_test.sv]
// Self-checking testbench of the reset status block
`include "rsb_cfg.svh"

module rsb_status_test;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    // Short counts keep each reset sequence to about a dozen cycles
    localparam int DRV = 2;
    localparam int XT  = 4;
    localparam logic [15:0] A_BRK  = `RSB_ADDR_BREAK_STATUS;
    localparam logic [15:0] A_RST  = `RSB_ADDR_RESET_STATUS;
    localparam logic [15:0] A_CTRL = `RSB_ADDR_BREAK_CTRL;
    localparam logic [15:0] A_IST  = `RSB_ADDR_IRQ_STATUS;
    localparam logic [15:0] A_IMSK = `RSB_ADDR_IRQ_MASK;

    logic                    sys_clk;
    logic                    rst;
    logic                    clk_en;
    logic [`RSB_ADDR_W-1:0]  reg_addr;
    logic [`RSB_DATA_W-1:0]  reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [`RSB_DATA_W-1:0]  reg_rdata;
    logic                    tick = 1'b0;
    logic                    ext_n;
    logic                    pin_n;
    logic                    rst_pin_out;
    logic                    rst_pin_oe;
    logic                    core_rst;
    logic                    brk_st;
    logic                    bwe;
    logic [4:0]              src;
    logic                    qual;
    logic                    irq;
    logic [7:0]              junk;
    int                      num_errors;
    int                      compares;
    int                      cycles = 0;

    // Pin has a pull-up, so a released external driver reads high
    assign pin_n = rst_pin_oe ? rst_pin_out : ext_n;

    rsb_status #(
        .DRIVE_CYC (DRV),
        .XTAL_CYC  (XT)
    ) i_dut (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .clk_en             (clk_en),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .crystal_clock_tick (tick),
        .rst_pin_n_in       (pin_n),
        .rst_pin_out        (rst_pin_out),
        .rst_pin_oe         (rst_pin_oe),
        .core_rst           (core_rst),
        .break_state        (brk_st),
        .break_wait_exit    (bwe),
        .watchdog_req       (src[0]),
        .bad_opcode_req     (src[1]),
        .bad_addr_req       (src[2]),
        .bad_addr_is_fetch  (qual),
        .monitor_entry_req  (src[3]),
        .vector_blank       (qual),
        .irq_pin_high       (qual),
        .low_voltage_req    (src[4]),
        .irq                (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #20 sys_clk = ~sys_clk;

    // Crystal tick every other cycle, so settle is twice as long as XT
    always @(posedge sys_clk) tick <= ~tick;

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_raw(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd_raw(a, d);
        chk8(nm, e, d);
    endtask

    task automatic pulse_bwe();
        @(posedge sys_clk);
        bwe <= 1'b1;
        @(posedge sys_clk);
        bwe <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (core_rst !== 1'b0 && n < 300)
        begin
            step();
            n++;
        end
        chk1("core_rst", 1'b0, core_rst);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic src_case(input int i, input logic q, input logic [7:0] e);
        @(posedge sys_clk);
        src[i] <= 1'b1;
        qual   <= q;
        @(posedge sys_clk);
        src <= '0;
        #1;
        chk1("rst_pin_oe", e != 8'h00, rst_pin_oe);
        wait_idle();
        rd(A_RST, e, "reset_source_status");
    endtask

    // External driver holds the pin low past or only partly into settle
    task automatic seq_pin(input logic hold, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge sys_clk);
        src[0] <= 1'b1;
        // Lowered only once driving starts, since a low pin while idle sets the flag
        @(posedge sys_clk);
        src   <= '0;
        ext_n <= 1'b0;
        #1;
        while (rst_pin_oe === 1'b1 && n < 50)
        begin
            step();
            n++;
        end
        chk8("drive_cycles", DRV[7:0], n[7:0]);
        repeat (hold ? 4 * XT : 1) @(posedge sys_clk);
        ext_n <= 1'b1;
        wait_idle();
        rd(A_RST, e, "reset_source_status");
    endtask

    task automatic pin_irq();
        wr(A_IMSK, 8'h02);
        rd_raw(A_IST, junk);
        @(posedge sys_clk);
        ext_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ext_n <= 1'b1;
        wait_idle();
        chk1("irq", 1'b1, irq);
        rd(A_RST, 8'h40, "reset_source_status");
        rd(A_IST, 8'h02, "irq_status");
        chk1("irq", 1'b0, irq);
        rd(A_RST, 8'h00, "reset_source_status");
    endtask

    task automatic brk_flag();
        wr(A_IMSK, 8'h01);
        rd_raw(A_IST, junk);
        rd(A_BRK, 8'h00, "break_status");
        pulse_bwe();
        step();
        chk1("irq", 1'b1, irq);
        rd(A_BRK, 8'h02, "break_status");
        rd(A_BRK, 8'h02, "break_status");
        wr(A_BRK, 8'h02);
        rd(A_BRK, 8'h02, "break_status");
        wr(A_BRK, 8'h00);
        rd(A_BRK, 8'h00, "break_status");
        rd(A_IST, 8'h01, "irq_status");
        chk1("irq", 1'b0, irq);
        wr(A_IMSK, 8'h00);
        pulse_bwe();
        step();
        chk1("irq", 1'b0, irq);
        rd(A_IMSK, 8'h00, "irq_mask");
    endtask

    task automatic gate();
        wr(A_CTRL, 8'h80);
        rd(A_CTRL, 8'h80, "break_flag_control");
        wr(A_CTRL, 8'h00);
        rd(A_CTRL, 8'h00, "break_flag_control");
        @(posedge sys_clk);
        brk_st <= 1'b1;
        src_case(0, 1'b1, 8'h20);
        src_case(1, 1'b1, 8'h30);
        wr(A_BRK, 8'h00);
        rd(A_BRK, 8'h02, "break_status");
        wr(A_CTRL, 8'h80);
        rd(A_RST, 8'h30, "reset_source_status");
        rd(A_RST, 8'h00, "reset_source_status");
        wr(A_BRK, 8'h00);
        rd(A_BRK, 8'h00, "break_status");
        @(posedge sys_clk);
        brk_st <= 1'b0;
        wr(A_CTRL, 8'h00);
    endtask

    // Events and strobes seen while the enable is low leave no trace
    task automatic freeze();
        @(posedge sys_clk);
        clk_en    <= 1'b0;
        bwe       <= 1'b1;
        reg_wr    <= 1'b1;
        reg_addr  <= A_CTRL;
        reg_wdata <= 8'h80;
        @(posedge sys_clk);
        clk_en <= 1'b1;
        bwe    <= 1'b0;
        reg_wr <= 1'b0;
        rd(A_BRK, 8'h00, "break_status");
        rd(A_CTRL, 8'h00, "break_flag_control");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk    = 1'b0;
        rst        = 1'b1;
        clk_en     = 1'b1;
        reg_addr   = '0;
        reg_wdata  = '0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        ext_n      = 1'b1;
        brk_st     = 1'b0;
        bwe        = 1'b0;
        src        = '0;
        qual       = 1'b0;
        num_errors = 0;
        compares   = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk1("rst_pin_oe", 1'b1, rst_pin_oe);
        chk1("rst_pin_out", 1'b0, rst_pin_out);
        chk1("core_rst", 1'b1, core_rst);
        wait_idle();
        rd(A_RST, 8'h80, "reset_source_status");
        rd(A_RST, 8'h00, "reset_source_status");
        rd(A_CTRL, 8'h00, "break_flag_control");
        rd(A_BRK, 8'h00, "break_status");
        src_case(0, 1'b1, 8'h20);
        src_case(1, 1'b1, 8'h10);
        src_case(2, 1'b1, 8'h08);
        src_case(2, 1'b0, 8'h00);
        src_case(3, 1'b1, 8'h04);
        src_case(3, 1'b0, 8'h00);
        src_case(4, 1'b1, 8'h02);
        seq_pin(1'b0, 8'h20);
        seq_pin(1'b1, 8'h60);
        pin_irq();
        brk_flag();
        gate();
        freeze();
        wr(16'hFE02, 8'hFF);
        rd(16'hFE02, 8'h00, "unmapped");
        rd(A_CTRL, 8'h00, "break_flag_control");
        end_of_test();
    end
endmodule
